// ===== shared/bfsb_pkg.sv
// package of constants and types for the bridge fault status bank
package bfsb_pkg;

   // -----------------------------------------------------------------
   // device size
   // -----------------------------------------------------------------
   localparam int BFSB_NUM_BRIDGES = 10;
   localparam int BFSB_OC_BITS     = 4;
   localparam int BFSB_OL_BITS     = 20;
   localparam int BFSB_DATA_BITS   = 8;
   // overcurrent flags held here start at bridge 9
   localparam int BFSB_OC_FIRST_BRIDGE = 9;

   // -----------------------------------------------------------------
   // field positions: bit = 2 * (bridge - first bridge) + side
   // -----------------------------------------------------------------
   localparam int BFSB_LOW_SIDE_OFS  = 0;
   localparam int BFSB_HIGH_SIDE_OFS = 1;
   localparam int BFSB_OL_1_4_LSB    = 0;
   localparam int BFSB_OL_5_8_LSB    = 8;
   localparam int BFSB_OL_9UP_LSB    = 16;
   localparam int BFSB_USED_9UP_BITS = 4;

   // -----------------------------------------------------------------
   // address byte layout: [op] code[4:0] [bank] 1
   // -----------------------------------------------------------------
   localparam int         BFSB_ADDR_OP_POS   = 7;
   localparam int         BFSB_ADDR_CODE_MSB = 6;
   localparam int         BFSB_ADDR_CODE_LSB = 2;
   localparam int         BFSB_ADDR_BANK_POS = 1;
   localparam int         BFSB_ADDR_TAIL_POS = 0;
   localparam logic       BFSB_ADDR_TAIL_VAL = 1'b1;
   localparam logic [4:0] BFSB_CODE_OC_9UP   = 5'h1e;
   localparam logic [4:0] BFSB_CODE_OL_1_4   = 5'h01;
   localparam logic [4:0] BFSB_CODE_OL_5_8   = 5'h11;
   localparam logic [4:0] BFSB_CODE_OL_9UP   = 5'h09;

   // -----------------------------------------------------------------
   // values after reset
   // -----------------------------------------------------------------
   localparam logic [3:0]  BFSB_OC_RESET   = 4'h0;
   localparam logic [19:0] BFSB_OL_RESET   = 20'h00000;
   localparam logic [7:0]  BFSB_DATA_RESET = 8'h00;
   localparam logic [7:0]  BFSB_DATA_ZERO  = 8'h00;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      BFSB_SEL_NONE,
      BFSB_SEL_OC_9UP,
      BFSB_SEL_OL_1_4,
      BFSB_SEL_OL_5_8,
      BFSB_SEL_OL_9UP
   } bfsb_reg_sel_t;

   typedef enum logic [0:0] {
      BFSB_LINK_IDLE,
      BFSB_LINK_WAIT
   } bfsb_link_state_t;

   typedef struct packed {
      logic [19:0] open_load;
      logic [3:0]  overcurrent;
   } bfsb_fault_vec_t;

   typedef struct packed {
      logic [7:0] data;
      logic       unmapped;
   } bfsb_read_rsp_t;

endpackage

// ===== hw/bfsb_sync2.sv
// two-flop level synchroniser, any width
`timescale 1ns/1ps
module bfsb_sync2 #(
   parameter int         WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and control
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             en_i,
   // data
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta_reg;

   // meta_reg feeds q_o only
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_reg <= RESET_VAL;
         q_o      <= RESET_VAL;
      end else if (en_i) begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end

endmodule

// ===== hw/bfsb_pulse_sync.sv
// toggle-based event crossing between two clock domains
`timescale 1ns/1ps
module bfsb_pulse_sync (
   // source domain
   input  wire logic src_clk_i,
   input  wire logic src_rst_n_i,
   input  wire logic src_en_i,
   input  wire logic src_pulse_i,
   // destination domain
   input  wire logic dst_clk_i,
   input  wire logic dst_rst_n_i,
   input  wire logic dst_en_i,
   output logic      dst_pulse_o
);

   logic tog_reg;
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge src_clk_i) begin
      if (!src_rst_n_i) begin
         tog_reg <= 1'b0;
      end else if (src_en_i && src_pulse_i) begin
         tog_reg <= ~tog_reg;
      end
   end

   // s1_reg is read by s2_reg alone
   always_ff @(posedge dst_clk_i) begin
      if (!dst_rst_n_i) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else if (dst_en_i) begin
         s1_reg <= tog_reg;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign dst_pulse_o = dst_en_i & (s2_reg ^ s3_reg);

endmodule

// ===== hw/bfsb_top.sv
// latched overcurrent and open-load status bank with serial read port
`timescale 1ns/1ps
module bfsb_top #(
   parameter int NUM_BRIDGES = bfsb_pkg::BFSB_NUM_BRIDGES
) (
   // system clock domain
   input  wire logic                     sys_clk_i,
   input  wire logic                     rst_n_i,
   input  wire logic                     clk_en_i,
   // fault detectors, asynchronous levels
   input  wire bfsb_pkg::bfsb_fault_vec_t fault_detect_i,
   // protection and status
   output logic [3:0]                    switch_off_o,
   output logic                          global_load_error_bit_o,
   output bfsb_pkg::bfsb_fault_vec_t     fault_flags_o,
   // serial frame side, link clock domain
   input  wire logic                     link_clk_i,
   input  wire logic                     rd_req_i,
   input  wire logic [7:0]               addr_byte_i,
   output logic                          rd_busy_o,
   output logic                          rd_valid_o,
   output logic [7:0]                    rd_data_o,
   output logic                          rd_unmapped_o
);
   import bfsb_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   bfsb_fault_vec_t  detect_s;
   logic [3:0]       oc_present;
   logic [19:0]      ol_present;
   logic [3:0]       oc_set;
   logic [19:0]      ol_set;
   logic [3:0]       oc_clr;
   logic [19:0]      ol_clr;
   logic [3:0]       oc_flags_reg;
   logic [19:0]      ol_flags_reg;
   logic [3:0]       oc_flags_next;
   logic [19:0]      ol_flags_next;
   logic             global_err_reg;
   logic [7:0]       rsp_data_reg;
   logic [7:0]       rsp_data_next;
   logic             grant_reg;
   logic             req_pulse;
   logic             ack_pulse;
   logic             link_rst_n;
   bfsb_link_state_t link_state_reg;
   bfsb_reg_sel_t    link_sel_reg;
   bfsb_reg_sel_t    addr_sel;
   logic             req_take;
   logic             rd_valid_reg;
   logic [7:0]       rd_data_reg;
   logic             rd_unmapped_reg;

   // ----------------------------------------------------------------
   // detector synchronisers and variant masks
   // ----------------------------------------------------------------
   bfsb_sync2 #(
      .WIDTH     ($bits(bfsb_fault_vec_t)),
      .RESET_VAL ({BFSB_OL_RESET, BFSB_OC_RESET})
   ) u_detect_sync (
      .clk_i   (sys_clk_i),
      .rst_n_i (rst_n_i),
      .en_i    (clk_en_i),
      .d_i     (fault_detect_i),
      .q_o     (detect_s)
   );

   // absent bridges never latch, so they read zero everywhere
   genvar gi;
   generate
      for (gi = 0; gi < BFSB_OL_BITS; gi++) begin : g_present
         assign ol_present[gi] = ((gi / 2) < NUM_BRIDGES);
         if (gi < BFSB_OC_BITS) begin : g_oc
            assign oc_present[gi] = ((BFSB_OC_FIRST_BRIDGE - 1 + gi / 2) < NUM_BRIDGES);
         end
      end
   endgenerate

   assign oc_set = detect_s.overcurrent & oc_present;
   assign ol_set = detect_s.open_load & ol_present;

   // ----------------------------------------------------------------
   // read decode on the sys side: value and clear vector
   // ----------------------------------------------------------------
   always_comb begin
      oc_clr        = '0;
      ol_clr        = '0;
      rsp_data_next = BFSB_DATA_ZERO;
      case (link_sel_reg)
         BFSB_SEL_OC_9UP: begin
            // upper nibble stays zero
            rsp_data_next = {4'h0, oc_flags_reg};
            oc_clr        = 4'hf;
         end
         BFSB_SEL_OL_1_4: begin
            rsp_data_next = ol_flags_reg[BFSB_OL_1_4_LSB +: 8];
            ol_clr        = 20'h000ff;
         end
         BFSB_SEL_OL_5_8: begin
            rsp_data_next = ol_flags_reg[BFSB_OL_5_8_LSB +: 8];
            ol_clr        = 20'h0ff00;
         end
         BFSB_SEL_OL_9UP: begin
            rsp_data_next = {4'h0, ol_flags_reg[BFSB_OL_9UP_LSB +: 4]};
            ol_clr        = 20'hf0000;
         end
         default: begin
            rsp_data_next = BFSB_DATA_ZERO;
         end
      endcase
      if (!req_pulse) begin
         oc_clr = '0;
         ol_clr = '0;
      end
   end

   // ----------------------------------------------------------------
   // latched flags: a fault present in the read cycle survives
   // ----------------------------------------------------------------
   assign oc_flags_next = (oc_flags_reg & ~oc_clr) | oc_set;
   assign ol_flags_next = (ol_flags_reg & ~ol_clr) | ol_set;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         oc_flags_reg <= BFSB_OC_RESET;
         ol_flags_reg <= BFSB_OL_RESET;
      end else if (clk_en_i) begin
         oc_flags_reg <= oc_flags_next;
         ol_flags_reg <= ol_flags_next;
      end
   end

   // one cycle behind the flags, glitch-free for the status register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         global_err_reg <= 1'b0;
      end else if (clk_en_i) begin
         global_err_reg <= (|oc_flags_reg) | (|ol_flags_reg);
      end
   end

   // response word is held until the next request, so the link side
   // can sample it any time after the acknowledge arrives
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rsp_data_reg <= BFSB_DATA_RESET;
         grant_reg    <= 1'b0;
      end else if (clk_en_i) begin
         grant_reg <= req_pulse;
         if (req_pulse) begin
            rsp_data_reg <= rsp_data_next;
         end
      end
   end

   assign switch_off_o            = oc_flags_reg;
   assign global_load_error_bit_o = global_err_reg;
   assign fault_flags_o           = {ol_flags_reg, oc_flags_reg};

   // ----------------------------------------------------------------
   // domain crossings
   // ----------------------------------------------------------------
   bfsb_sync2 #(
      .WIDTH     (1),
      .RESET_VAL (1'b0)
   ) u_link_rst_sync (
      .clk_i   (link_clk_i),
      .rst_n_i (1'b1),
      .en_i    (1'b1),
      .d_i     (rst_n_i),
      .q_o     (link_rst_n)
   );

   bfsb_pulse_sync u_req_sync (
      .src_clk_i   (link_clk_i),
      .src_rst_n_i (link_rst_n),
      .src_en_i    (1'b1),
      .src_pulse_i (req_take),
      .dst_clk_i   (sys_clk_i),
      .dst_rst_n_i (rst_n_i),
      .dst_en_i    (clk_en_i),
      .dst_pulse_o (req_pulse)
   );

   bfsb_pulse_sync u_ack_sync (
      .src_clk_i   (sys_clk_i),
      .src_rst_n_i (rst_n_i),
      .src_en_i    (clk_en_i),
      .src_pulse_i (grant_reg),
      .dst_clk_i   (link_clk_i),
      .dst_rst_n_i (link_rst_n),
      .dst_en_i    (1'b1),
      .dst_pulse_o (ack_pulse)
   );

   // ----------------------------------------------------------------
   // link side: address byte decode and read sequencing
   // ----------------------------------------------------------------
   // operation and bank bits are not checked here; frame logic owns them
   always_comb begin
      addr_sel = BFSB_SEL_NONE;
      if (addr_byte_i[BFSB_ADDR_TAIL_POS] == BFSB_ADDR_TAIL_VAL) begin
         case (addr_byte_i[BFSB_ADDR_CODE_MSB:BFSB_ADDR_CODE_LSB])
            BFSB_CODE_OC_9UP: addr_sel = BFSB_SEL_OC_9UP;
            BFSB_CODE_OL_1_4: addr_sel = BFSB_SEL_OL_1_4;
            BFSB_CODE_OL_5_8: addr_sel = BFSB_SEL_OL_5_8;
            BFSB_CODE_OL_9UP: addr_sel = BFSB_SEL_OL_9UP;
            default:          addr_sel = BFSB_SEL_NONE;
         endcase
      end
   end

   assign req_take = (link_state_reg == BFSB_LINK_IDLE) && rd_req_i &&
                     (addr_sel != BFSB_SEL_NONE);

   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n) begin
         link_state_reg <= BFSB_LINK_IDLE;
      end else begin
         case (link_state_reg)
            BFSB_LINK_IDLE: begin
               if (req_take) begin
                  link_state_reg <= BFSB_LINK_WAIT;
               end
            end
            BFSB_LINK_WAIT: begin
               if (ack_pulse) begin
                  link_state_reg <= BFSB_LINK_IDLE;
               end
            end
            default: begin
               link_state_reg <= BFSB_LINK_IDLE;
            end
         endcase
      end
   end

   // held stable while waiting; the sys side reads it on req_pulse
   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n) begin
         link_sel_reg <= BFSB_SEL_NONE;
      end else if (req_take) begin
         link_sel_reg <= addr_sel;
      end
   end

   // unmapped codes answer at once with zero, nothing crosses
   always_ff @(posedge link_clk_i) begin
      if (!link_rst_n) begin
         rd_valid_reg    <= 1'b0;
         rd_data_reg     <= BFSB_DATA_RESET;
         rd_unmapped_reg <= 1'b0;
      end else begin
         rd_valid_reg <= 1'b0;
         if ((link_state_reg == BFSB_LINK_WAIT) && ack_pulse) begin
            rd_valid_reg    <= 1'b1;
            rd_data_reg     <= rsp_data_reg;
            rd_unmapped_reg <= 1'b0;
         end else if ((link_state_reg == BFSB_LINK_IDLE) && rd_req_i &&
                      (addr_sel == BFSB_SEL_NONE)) begin
            rd_valid_reg    <= 1'b1;
            rd_data_reg     <= BFSB_DATA_ZERO;
            rd_unmapped_reg <= 1'b1;
         end
      end
   end

   assign rd_busy_o     = (link_state_reg == BFSB_LINK_WAIT);
   assign rd_valid_o    = rd_valid_reg;
   assign rd_data_o     = rd_data_reg;
   assign rd_unmapped_o = rd_unmapped_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence seq_req_taken;
      req_take;
   endsequence

   sequence seq_answer;
      rd_busy_o ##[2:199] (rd_valid_o && !rd_unmapped_o && !rd_busy_o);
   endsequence

   sequence seq_read_grant(bfsb_reg_sel_t sel);
      clk_en_i && req_pulse && (link_sel_reg == sel);
   endsequence

   chk_oc_latch_set: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && (oc_set != 4'h0)) |=>
         ((oc_flags_reg & $past(oc_set)) == $past(oc_set)) &&
         ((switch_off_o & $past(oc_set)) == $past(oc_set)))
      else $error("overcurrent did not latch or switch stayed on");

   chk_oc_layout_read: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      seq_read_grant(BFSB_SEL_OC_9UP) |=>
         (rsp_data_reg[3:0] == $past(oc_flags_reg)))
      else $error("overcurrent 9up read word wrong");

   chk_reserved_zero: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (req_pulse && clk_en_i && (link_sel_reg inside {BFSB_SEL_OC_9UP, BFSB_SEL_OL_9UP})) |=>
         (rsp_data_reg[7:4] == 4'h0))
      else $error("reserved bits read nonzero");

   chk_flags_reset: assert property (
      @(posedge sys_clk_i)
      !rst_n_i |=> (oc_flags_reg == 4'h0) && (ol_flags_reg == 20'h00000) &&
                   !global_load_error_bit_o)
      else $error("flags not zero after reset");

   chk_ol_no_shutdown: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && (ol_set != 20'h00000) && (oc_set == 4'h0) && !req_pulse) |=>
         ((ol_flags_reg & $past(ol_set)) == $past(ol_set)) &&
         (switch_off_o == $past(switch_off_o)))
      else $error("open load not latched or switch changed");

   chk_ol_low_layout: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      seq_read_grant(BFSB_SEL_OL_1_4) |=> (rsp_data_reg == $past(ol_flags_reg[7:0])))
      else $error("open-load 1-4 read word wrong");

   chk_ol_mid_layout: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      seq_read_grant(BFSB_SEL_OL_5_8) |=> (rsp_data_reg == $past(ol_flags_reg[15:8])))
      else $error("open-load 5-8 read word wrong");

   chk_ol_high_layout: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      seq_read_grant(BFSB_SEL_OL_9UP) |=>
         (rsp_data_reg == {4'h0, $past(ol_flags_reg[19:16])}))
      else $error("open-load 9up read word wrong");

   chk_absent_zero: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      ((oc_flags_reg & ~oc_present) == 4'h0) && ((ol_flags_reg & ~ol_present) == 20'h00000))
      else $error("absent bridge flag set");

   chk_global_error: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i |=> (global_load_error_bit_o ==
                    ($past(|oc_flags_reg) | $past(|ol_flags_reg))))
      else $error("global error bit not OR of flags");

   chk_read_clears: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (seq_read_grant(BFSB_SEL_OL_1_4) ##0 (ol_set[7:0] == 8'h00)) |=>
         (ol_flags_reg[7:0] == 8'h00))
      else $error("read did not clear open-load 1-4");

   chk_link_answer: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_n)
      seq_req_taken |=> seq_answer)
      else $error("read request not answered in time");

endmodule

// ===== verif/bfsb_host_model.sv
// host model issuing status reads on the link clock
`timescale 1ns/1ps
module bfsb_host_model (
   // link clock
   input  wire logic       link_clk_i,
   // answer side of the bank
   input  wire logic       rd_busy_i,
   input  wire logic       rd_valid_i,
   // request side of the bank
   output logic            rd_req_o,
   output logic [7:0]      addr_byte_o
);
   initial begin
      rd_req_o    = 1'b0;
      addr_byte_o = 8'h00;
   end

   // -----------------------------------------------------------------
   // one outstanding read, held until the edge that takes it
   // -----------------------------------------------------------------
   task automatic read(input logic [7:0] addr, output bit ok);
      int n;
      ok = 1'b0;
      @(negedge link_clk_i);
      rd_req_o    = 1'b1;
      addr_byte_o = addr;
      for (n = 0; n < 300 && !ok; n++) begin
         @(posedge link_clk_i);
         ok = (rd_busy_i === 1'b0);
      end
      @(negedge link_clk_i);
      rd_req_o    = 1'b0;
      // a released line must not keep showing the last value
      addr_byte_o = ~addr;
      ok = 1'b0;
      for (n = 0; n < 300 && !ok; n++) begin
         @(posedge link_clk_i);
         ok = (rd_valid_i === 1'b1);
      end
   endtask
endmodule

// ===== verif/test_bridge_fault_status_bank.sv
// self-checking bench for the bridge fault status bank
`timescale 1ns/1ps
module test_bridge_fault_status_bank;
   import bfsb_pkg::*;
   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   logic            sys_clk_i, link_clk_i, rst_n_i, clk_en_i;
   bfsb_fault_vec_t fault_detect_i, fault_flags_o, small_flags;
   logic [3:0]      switch_off_o;
   logic            global_load_error_bit_o, rd_req_i, rd_busy_o;
   logic            rd_valid_o, rd_unmapped_o;
   logic [7:0]      addr_byte_i, rd_data_o;
   logic [19:0]     p, small_ol;
   int              n_mismatch, checks_done;
   logic [8:0]      exp_q[$];

   bfsb_top u_dut (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
      .fault_detect_i(fault_detect_i), .switch_off_o(switch_off_o),
      .global_load_error_bit_o(global_load_error_bit_o), .fault_flags_o(fault_flags_o),
      .link_clk_i(link_clk_i), .rd_req_i(rd_req_i), .addr_byte_i(addr_byte_i),
      .rd_busy_o(rd_busy_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
      .rd_unmapped_o(rd_unmapped_o)
   );
   // smaller variant: only its flag outputs are watched
   bfsb_top #(.NUM_BRIDGES(8)) u_small (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
      .fault_detect_i(fault_detect_i), .switch_off_o(), .global_load_error_bit_o(),
      .fault_flags_o(small_flags), .link_clk_i(link_clk_i), .rd_req_i(1'b0),
      .addr_byte_i(8'h00), .rd_busy_o(), .rd_valid_o(), .rd_data_o(), .rd_unmapped_o()
   );
   bfsb_host_model u_host (
      .link_clk_i(link_clk_i), .rd_busy_i(rd_busy_o), .rd_valid_i(rd_valid_o),
      .rd_req_o(rd_req_i), .addr_byte_o(addr_byte_i)
   );

   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   // phase offset keeps the two clocks unrelated
   initial begin
      link_clk_i = 1'b0;
      #7;
      forever #15 link_clk_i = ~link_clk_i;
   end

   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // op and bank bits are random, the tail bit is set
   function automatic logic [7:0] ad(input logic [4:0] code);
      ad = {1'($urandom), code, 1'($urandom), BFSB_ADDR_TAIL_VAL};
   endfunction

   // expected answer is {data, unmapped}
   task automatic rd(input logic [7:0] a, input logic [8:0] exp);
      bit ok;
      exp_q.push_back(exp);
      u_host.read(a, ok);
      if (!ok) begin
         n_mismatch++;
         $display("Error read answer expected valid seen none");
      end
   endtask

   task automatic pulse_fault(input bfsb_fault_vec_t f);
      @(negedge sys_clk_i);
      fault_detect_i = f;
      repeat (4) @(negedge sys_clk_i);
      fault_detect_i = '0;
      // the small variant is never read, so its flags pile up
      small_ol = small_ol | (f.open_load & 20'h0ffff);
      repeat (2) @(negedge sys_clk_i);
      check("latched flags", f, fault_flags_o);
      check("switch off", 24'(f.overcurrent), 24'(switch_off_o));
      check("global error", 24'(f != '0), 24'(global_load_error_bit_o));
      check("small variant flags", {small_ol, 4'h0}, small_flags);
   endtask

   // -----------------------------------------------------------------
   // answer monitor: oldest note against each answer
   // -----------------------------------------------------------------
   // sampled mid-cycle, clear of the edge that launches the answer
   always @(negedge link_clk_i) begin
      if (rd_valid_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_mismatch++;
            $display("Error read answer expected none seen %h", rd_data_o);
         end else begin
            check("read answer", 24'(exp_q.pop_front()),
                  24'({rd_data_o, rd_unmapped_o}));
         end
      end
   end

   initial begin
      #500000;
      n_mismatch++;
      $display("Error watchdog expected end seen hang");
      give_verdict();
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      rst_n_i        = 1'b0;
      clk_en_i       = 1'b1;
      fault_detect_i = '0;
      n_mismatch     = 0;
      checks_done    = 0;
      small_ol       = '0;
      p              = 20'($urandom(74));
      repeat (10) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(posedge link_clk_i);
      check("flags after reset", 24'h000000, fault_flags_o);
      rd(ad(BFSB_CODE_OC_9UP), 9'h000);
      rd(ad(BFSB_CODE_OL_1_4), 9'h000);
      rd(ad(BFSB_CODE_OL_5_8), 9'h000);
      rd(ad(BFSB_CODE_OL_9UP), 9'h000);
      $display("test reset values done");

      // a fault seen only while the clock is held off leaves no trace
      @(negedge sys_clk_i);
      clk_en_i       = 1'b0;
      fault_detect_i = '1;
      repeat (6) @(negedge sys_clk_i);
      fault_detect_i = '0;
      check("flags while frozen", 24'h000000, fault_flags_o);
      clk_en_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      check("flags after freeze", 24'h000000, fault_flags_o);
      $display("test clock enable done");

      for (int b = 0; b < 4; b++) begin
         pulse_fault({20'h00000, 4'(1 << b)});
         // unmapped reads come back at once and clear nothing
         rd({1'b1, BFSB_CODE_OC_9UP, 2'b10}, 9'h001);
         rd(ad(5'h1f), 9'h001);
         rd(ad(BFSB_CODE_OC_9UP), {4'h0, 4'(1 << b), 1'b0});
         rd(ad(BFSB_CODE_OC_9UP), 9'h000);
      end
      $display("test overcurrent done");

      for (int k = 0; k < 3; k++) begin
         p = 20'($urandom);
         pulse_fault({p, 4'h0});
         rd(ad(BFSB_CODE_OL_9UP), {4'h0, p[19:16], 1'b0});
         rd(ad(BFSB_CODE_OL_5_8), {p[15:8], 1'b0});
         rd(ad(BFSB_CODE_OL_1_4), {p[7:0], 1'b0});
         rd(ad(BFSB_CODE_OL_1_4), 9'h000);
      end
      repeat (3) @(negedge sys_clk_i);
      check("global after clear", 24'h000000, 24'(global_load_error_bit_o));
      $display("test open load done");

      // a fault still present wins over the clear of a read
      @(negedge sys_clk_i);
      fault_detect_i.overcurrent = 4'h8;
      repeat (4) @(negedge sys_clk_i);
      rd(ad(BFSB_CODE_OC_9UP), 9'h010);
      rd(ad(BFSB_CODE_OC_9UP), 9'h010);
      @(negedge sys_clk_i);
      fault_detect_i = '0;
      repeat (4) @(negedge sys_clk_i);
      rd(ad(BFSB_CODE_OC_9UP), 9'h010);
      rd(ad(BFSB_CODE_OC_9UP), 9'h000);
      check("switch off after clear", 24'h000000, 24'(switch_off_o));
      check("notes left", 24'h000000, 24'(exp_q.size()));
      $display("test persisting fault done");
      give_verdict();
   end
endmodule
